// ===== dv/sewg_guard_chk.sv
// Checker of the write-state guard, seen from its top-level pins
`timescale 1ns/10ps
module sewg_guard_chk #(
  parameter int WRITE_CYCLES = sewg_pkg::WRITE_CYCLES  // Internal write length
) (
  input wire logic clock,       // System clock
  input wire logic rst_n,       // Synchronous reset, active low
  input wire logic por_ok,      // Supply above trigger
  input wire logic spi_cs_n,    // Chip select
  input wire logic spi_sck,     // Serial clock
  input wire logic spi_si,      // Serial data in
  input wire logic spi_so,      // Serial data out
  input wire logic spi_so_oe_n, // Output enable, low while driving
  input wire logic standby,     // Standby level
  input wire logic write_busy   // Internal write running
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [15:0] busy_cnt_q;  // Busy length so far
  // Counts busy cycles; a plain repetition would be far too long
  always_ff @(posedge clock) begin
    if (!rst_n) busy_cnt_q <= 16'h0000;
    else        busy_cnt_q <= write_busy ? busy_cnt_q + 16'h0001 : 16'h0000;
  end
  property p_oe_desel; $past(spi_cs_n) |-> spi_so_oe_n; endproperty
  a_oe_desel: assert property (p_oe_desel) else $error("output driven while deselected");
  property p_standby_por; !por_ok |=> !standby; endproperty
  a_standby_por: assert property (p_standby_por) else $error("standby kept after supply loss");
  property p_busy_por; !por_ok [*2] |=> !write_busy; endproperty
  a_busy_por: assert property (p_busy_por) else $error("busy kept after supply loss");
  property p_standby_def; standby |-> spi_cs_n && !write_busy; endproperty
  a_standby_def: assert property (p_standby_def) else $error("standby while selected or busy");
  property p_standby_ret;
    $past(rst_n) && por_ok && $past(por_ok) && spi_cs_n && $past(spi_cs_n) && !write_busy
      |-> standby;
  endproperty
  a_standby_ret: assert property (p_standby_ret) else $error("standby not entered");
  property p_busy_start; $rose(write_busy) |-> spi_cs_n && $past(spi_cs_n); endproperty
  a_busy_start: assert property (p_busy_start) else $error("write began while selected");
  property p_busy_len; $fell(write_busy) && por_ok |-> busy_cnt_q == 16'(WRITE_CYCLES); endproperty
  a_busy_len: assert property (p_busy_len) else $error("internal write length wrong");
  property p_so_edge;
    !spi_so_oe_n && !$past(spi_so_oe_n) && $changed(spi_so) |-> $past(spi_sck, 2) && !$past(spi_sck);
  endproperty
  a_so_edge: assert property (p_so_edge) else $error("output moved off a clock fall");
  property p_reset_out; $rose(rst_n) |-> spi_so_oe_n && !write_busy && !standby; endproperty
  a_reset_out: assert property (p_reset_out) else $error("outputs wrong out of reset");
  c_busy: cover property ($rose(write_busy));
  c_drive: cover property ($fell(spi_so_oe_n));
  c_brown: cover property ($fell(por_ok));
endmodule : sewg_guard_chk
bind sewg_guard sewg_guard_chk #(.WRITE_CYCLES(WRITE_CYCLES)) chk_u (.clock(clock),
  .rst_n(rst_n), .por_ok(por_ok), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_si(spi_si),
  .spi_so(spi_so), .spi_so_oe_n(spi_so_oe_n), .standby(standby), .write_busy(write_busy));

// ===== dv/sewg_host.sv
// SPI host model driving the guard in mode 0
`timescale 1ns/10ps
module sewg_host (
  input  wire logic clock, // System clock
  output logic      cs_n,  // Chip select
  output logic      sck,   // Serial clock, still outside frames
  output logic      si,    // Serial data out to the device
  input  wire logic so,    // Serial data from the device
  input  wire logic oe_n   // Device output enable
);
  logic drove = 1'b0;  // Device drove its output in this frame
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end
  // Remembers any driving of the output line
  always @(posedge clock) begin
    if (oe_n === 1'b0) drove = 1'b1;
  end
  // Waits edges, then steps just past the last one
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  // Selects before any instruction bit
  task automatic sel();
    tick(1);
    drove = 1'b0;
    cs_n  = 1'b0;
    tick(2);
  endtask : sel
  // One byte each way, sck edges two clocks apart
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si = tx[i];
      tick(2);
      rx[i] = (oe_n === 1'b0) ? so : ~so;  // Released line reads as junk
      sck = 1'b1;
      tick(2);
      sck = 1'b0;
    end
  endtask : xfer
  // Releases only on a byte boundary; idle data shows a changed level
  task automatic desel();
    tick(2);
    cs_n = 1'b1;
    si   = ~si;
    tick(3);
  endtask : desel
endmodule : sewg_host

// ===== dv/testbench.sv
// Self-checking bench of the write-state guard
`timescale 1ns/10ps
module testbench;
  localparam int WC = 400;  // Shortened write, outlasts a status poll
  logic clock = 1'b0;  // System clock
  logic rst_n = 1'b0;  // Reset, active low
  logic por_ok = 1'b1; // Supply good
  logic cs_n, sck, si, so, oe_n, standby, busy;  // Device pins
  logic [7:0] rx;      // Last byte read
  int n_mismatch = 0;  // Mismatches seen
  int total_checks = 0; // Comparisons made
  int cyc = 0;         // Cycle count for the hang limit
  always #2.5 clock = ~clock;
  sewg_guard #(.WRITE_CYCLES(WC)) dut_u (.clock(clock), .rst_n(rst_n), .por_ok(por_ok),
    .spi_cs_n(cs_n), .spi_sck(sck), .spi_si(si), .spi_so(so), .spi_so_oe_n(oe_n),
    .standby(standby), .write_busy(busy));
  sewg_host host_u (.clock(clock), .cs_n(cs_n), .sck(sck), .si(si), .so(so), .oe_n(oe_n));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done();
    $display("mismatches=%0d checks=%0d", n_mismatch, total_checks);
    if (n_mismatch == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done
  // Hang limit, far beyond the planned run
  always @(posedge clock) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      test_done();
    end
  end
  // Frame helpers
  task automatic cmd(input logic [7:0] op);
    host_u.sel();
    host_u.xfer(op, rx);
    host_u.desel();
  endtask : cmd
  task automatic frame(input logic [7:0] op, input logic [15:0] a, input int n, input logic [7:0] d);
    host_u.sel();
    host_u.xfer(op, rx);
    host_u.xfer(a[15:8], rx);
    host_u.xfer(a[7:0], rx);
    if (n > 0) host_u.xfer(d, rx);
    host_u.desel();
  endtask : frame
  task automatic status(output logic [7:0] s);
    host_u.sel();
    host_u.xfer(sewg_pkg::OP_STATUS_READ_CMD, rx);
    host_u.xfer(8'h00, s);
    host_u.desel();
  endtask : status
  // Scenarios
  task automatic t_powerup();
    check({standby, busy}, 8'h02);
    status(rx);
    check(rx, sewg_pkg::STATUS_RST);
  endtask : t_powerup
  task automatic t_nolatch_badop();
    frame(sewg_pkg::OP_WRITE, 16'h0010, 1, 8'hA5);
    check(busy, 8'h00);
    cmd(8'hA5);
    check(host_u.drove, 8'h00);
    status(rx);
    check(rx, 8'h00);
  endtask : t_nolatch_badop
  task automatic t_latch();
    cmd(sewg_pkg::OP_WRITE_LATCH_SET_CMD);
    status(rx);
    check(rx, 8'h02);
    cmd(sewg_pkg::OP_WRITE_LATCH_CLEAR_CMD);
    status(rx);
    check(rx, 8'h00);
  endtask : t_latch
  task automatic t_write();
    cmd(sewg_pkg::OP_WRITE_LATCH_SET_CMD);
    frame(sewg_pkg::OP_WRITE, 16'h0010, 0, 8'h00);
    check(busy, 8'h00);
    frame(sewg_pkg::OP_WRITE, 16'h0010, 1, 8'h5A);
    check(busy, 8'h01);
    status(rx);
    check(rx, 8'h03);
    frame(sewg_pkg::OP_READ, 16'h0010, 1, 8'h00);
    check(host_u.drove, 8'h00);
    for (int i = 0; i < WC && busy === 1'b1; i++) host_u.tick(1);
    status(rx);
    check(rx, 8'h00);
    frame(sewg_pkg::OP_READ, 16'h0010, 1, 8'h00);
    check(rx, 8'h5A);
  endtask : t_write
  task automatic t_brownout();
    cmd(sewg_pkg::OP_WRITE_LATCH_SET_CMD);
    por_ok = 1'b0;
    host_u.tick(3);
    check(standby, 8'h00);
    por_ok = 1'b1;
    host_u.tick(3);
    check(standby, 8'h01);
    status(rx);
    check(rx, 8'h00);
  endtask : t_brownout
  // Status write: a two-byte frame is void, a one-byte frame commits
  task automatic t_wrsr();
    cmd(sewg_pkg::OP_WRITE_LATCH_SET_CMD);
    host_u.sel();
    host_u.xfer(sewg_pkg::OP_WRSR, rx);
    host_u.xfer(8'hFF, rx);
    host_u.xfer(8'hFF, rx);
    host_u.desel();
    check(busy, 8'h00);
    host_u.sel();
    host_u.xfer(sewg_pkg::OP_WRSR, rx);
    host_u.xfer(8'h8C, rx);
    host_u.desel();
    check(busy, 8'h01);
    for (int i = 0; i < WC && busy === 1'b1; i++) host_u.tick(1);
    status(rx);
    check(rx, 8'h8C);
  endtask : t_wrsr
  // Main sequence
  initial begin
    host_u.tick(16);
    rst_n = 1'b1;
    host_u.tick(3);
    t_powerup();
    t_nolatch_badop();
    t_latch();
    t_write();
    t_brownout();
    t_wrsr();
    test_done();
  end
endmodule : testbench

// ===== verilog/sewg_guard.sv
// Serial EEPROM slave with power-on and write-state guarding
`timescale 1ns/10ps
module sewg_guard #(
  parameter int WRITE_CYCLES = sewg_pkg::WRITE_CYCLES,  // Internal write length
  parameter int ADDR_W       = sewg_pkg::ADDR_W,        // Significant address bits
  parameter int PAGE_BITS    = sewg_pkg::PAGE_BITS      // Page offset bits
) (
  input  wire logic clock,       // System clock, 200 MHz
  input  wire logic rst_n,       // Synchronous reset, active low
  input  wire logic por_ok,      // Supply above detector trigger
  input  wire logic spi_cs_n,    // Chip select, active low
  input  wire logic spi_sck,     // Serial clock, mode 0
  input  wire logic spi_si,      // Serial data in
  output logic      spi_so,      // Serial data out
  output logic      spi_so_oe_n, // Output enable, low while driving
  output logic      standby,     // Idle in low-power standby
  output logic      write_busy   // Internal write in progress
);
  localparam int DEPTH = 1 << ADDR_W;
  localparam int PAGE  = 1 << PAGE_BITS;

  sewg_wc_if wc ();

  sewg_pkg::sewg_pwr_type pwr_q;       // Supply state
  sewg_pkg::sewg_st_type  st_q;        // Selection state
  logic                   sck_q;       // Previous serial clock
  logic                   cs_q;        // Previous chip select
  logic                   armed_q;     // Chip select seen high since power-up
  logic [2:0]             bit_q;       // Bit within byte
  logic [7:0]             sr_q;        // Input shift register
  logic [7:0]             op_q;        // Current opcode
  logic                   adr_hi_q;    // First address byte taken
  logic [15:0]            adr_q;       // Received address
  logic                   got_q;       // At least one data byte taken
  logic                   write_latch_bit_q; // Write latch
  logic                   wpen_q;      // Status bit 7
  logic [1:0]             bp_q;        // Block protect bits
  logic [7:0]             sr_new_q;    // Pending status write value
  logic                   sr_kind_q;   // Pending write targets status
  logic [ADDR_W-1:0]      rd_adr_q;    // Read pointer
  logic [ADDR_W-PAGE_BITS-1:0] page_q; // Page being loaded
  logic [PAGE_BITS-1:0]   off_q;       // Offset in page
  logic [7:0]             pbuf [PAGE]; // Page load buffer
  logic [PAGE-1:0]        pval_q;      // Loaded buffer entries
  logic [7:0]             mem [DEPTH]; // Array
  logic [7:0]             osr_q;       // Output shift register
  logic [2:0]             obit_q;      // Output bit count

  logic       pwr_up;     // Standby, logic running
  logic       sck_rise;   // Sampling edge
  logic       sck_fall;   // Shifting edge
  logic       cs_rise;    // Selection ended
  logic       cs_fall;    // Selection began
  logic       byte_done;  // Eighth bit of a byte this cycle
  logic [7:0] byte_in;    // Completed byte
  logic [7:0] status;     // Status register view
  logic       exact;      // Release on a byte boundary

  assign pwr_up    = (pwr_q == sewg_pkg::pw_standby);
  assign sck_rise  = spi_sck & ~sck_q;
  assign sck_fall  = ~spi_sck & sck_q;
  assign cs_rise   = spi_cs_n & ~cs_q;
  assign cs_fall   = ~spi_cs_n & cs_q;
  assign byte_in   = {sr_q[6:0], spi_si};
  assign byte_done = sck_rise && !spi_cs_n && (st_q != sewg_pkg::st_idle) && (bit_q == 3'h7);
  assign exact     = (bit_q == 3'h0);
  assign status    = {wpen_q, 3'h0, bp_q, write_latch_bit_q, wc.busy};
  assign write_busy = wc.busy;
  assign standby   = pwr_up && spi_cs_n && !wc.busy;

  // Detector level moves the part between reset and standby both ways
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pwr_q <= sewg_pkg::pw_reset;
    end else begin
      pwr_q <= por_ok ? sewg_pkg::pw_standby : sewg_pkg::pw_reset;
    end
  end

  // Edge history and arming; a select held low through power-up is not a start
  always_ff @(posedge clock) begin
    if (!rst_n || !pwr_up) begin
      sck_q   <= 1'b0;
      cs_q    <= 1'b1;  // Idle level of select, so no false rise after reset
      armed_q <= 1'b0;
    end else begin
      sck_q <= spi_sck;
      cs_q  <= spi_cs_n;
      if (spi_cs_n) begin
        armed_q <= 1'b1;
      end
    end
  end

  // Bit shifting and the selection state machine
  always_ff @(posedge clock) begin
    if (!rst_n || !pwr_up) begin
      st_q     <= sewg_pkg::st_idle;
      bit_q    <= 3'h0;
      sr_q     <= 8'h00;
      op_q     <= 8'h00;
      adr_hi_q <= 1'b0;
      adr_q    <= 16'h0000;
      got_q    <= 1'b0;
    end else if (spi_cs_n) begin
      st_q <= sewg_pkg::st_idle;  // Selection over
    end else if (st_q == sewg_pkg::st_idle) begin
      if (cs_fall && armed_q) begin
        st_q     <= sewg_pkg::st_op;
        bit_q    <= 3'h0;
        adr_hi_q <= 1'b0;
        got_q    <= 1'b0;
      end
    end else if (sck_rise) begin
      sr_q  <= byte_in;
      bit_q <= bit_q + 3'h1;
      if (byte_done) begin
        case (st_q)
          sewg_pkg::st_op: begin
            op_q <= byte_in;
            if (wc.busy && byte_in != sewg_pkg::OP_STATUS_READ_CMD) begin
              st_q <= sewg_pkg::st_ignore;
            end else begin
              case (byte_in)
                sewg_pkg::OP_STATUS_READ_CMD:       st_q <= sewg_pkg::st_read;
                sewg_pkg::OP_WRITE_LATCH_SET_CMD,
                sewg_pkg::OP_WRITE_LATCH_CLEAR_CMD: st_q <= sewg_pkg::st_cmd;
                sewg_pkg::OP_READ,
                sewg_pkg::OP_WRITE:                 st_q <= sewg_pkg::st_addr;
                sewg_pkg::OP_WRSR:                  st_q <= sewg_pkg::st_wrsr;
                default:                            st_q <= sewg_pkg::st_ignore;
              endcase
            end
          end
          sewg_pkg::st_addr: begin
            adr_q    <= {adr_q[7:0], byte_in};
            adr_hi_q <= 1'b1;
            if (adr_hi_q) begin
              st_q <= (op_q == sewg_pkg::OP_READ) ? sewg_pkg::st_read : sewg_pkg::st_wdata;
            end
          end
          sewg_pkg::st_wdata: got_q <= 1'b1;
          sewg_pkg::st_wrsr: begin
            // A second byte spoils the frame length
            if (got_q) begin
              st_q <= sewg_pkg::st_ignore;
            end
            got_q <= 1'b1;
          end
          sewg_pkg::st_cmd:  st_q <= sewg_pkg::st_ignore;  // Trailing bits void it
          default:           st_q <= st_q;
        endcase
      end
    end
  end

  // Page loading; offset rolls over within the page
  always_ff @(posedge clock) begin
    if (!rst_n || !pwr_up) begin
      page_q <= '0;
      off_q  <= '0;
      pval_q <= '0;
    end else if (byte_done && st_q == sewg_pkg::st_addr && adr_hi_q) begin
      page_q <= {adr_q[ADDR_W-9:0], byte_in[7:PAGE_BITS]};  // Upper address bits pick the page
      off_q  <= byte_in[PAGE_BITS-1:0];
      if (!wc.busy) begin
        pval_q <= '0;
      end
    end else if (byte_done && st_q == sewg_pkg::st_wdata) begin
      pbuf[off_q]   <= byte_in;
      pval_q[off_q] <= 1'b1;
      off_q         <= off_q + PAGE_BITS'(1);
    end
  end

  // Write latch, pending status value, and write start on release
  always_ff @(posedge clock) begin
    if (!rst_n || !pwr_up) begin
      write_latch_bit_q <= 1'b0;
      sr_new_q  <= sewg_pkg::STATUS_RST;
      sr_kind_q <= 1'b0;
    end else begin
      if (byte_done && st_q == sewg_pkg::st_wrsr) begin
        sr_new_q <= byte_in;
      end
      if (wc.done) begin
        write_latch_bit_q <= 1'b0;
      end else if (cs_rise && st_q == sewg_pkg::st_cmd && exact) begin
        // Latch commands take effect only when select is raised
        if (op_q == sewg_pkg::OP_WRITE_LATCH_SET_CMD) begin
          write_latch_bit_q <= 1'b1;
        end else begin
          write_latch_bit_q <= 1'b0;
        end
      end
      if (wc.start) begin
        sr_kind_q <= (st_q == sewg_pkg::st_wrsr);
      end
    end
  end

  // Only a whole, byte-aligned, enabled write frame starts programming
  assign wc.start = cs_rise && exact && got_q && write_latch_bit_q && !wc.busy &&
                    (st_q == sewg_pkg::st_wdata || st_q == sewg_pkg::st_wrsr);

  // Commit at the end of the internal write; the array never sees bus traffic
  always_ff @(posedge clock) begin
    if (wc.done && !sr_kind_q) begin
      for (int i = 0; i < PAGE; i++) begin
        if (pval_q[i]) begin
          mem[{page_q, PAGE_BITS'(i)}] <= pbuf[i];
        end
      end
    end
  end

  // Non-volatile status bits; only bits 7, 3 and 2 are writable
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wpen_q <= 1'b0;
      bp_q   <= 2'h0;
    end else if (wc.done && sr_kind_q) begin
      wpen_q <= sr_new_q[sewg_pkg::STAT_WPEN];
      bp_q   <= {sr_new_q[sewg_pkg::STAT_BP1], sr_new_q[sewg_pkg::STAT_BP0]};
    end
  end

  // Serial output on falling edges; released outside read states
  always_ff @(posedge clock) begin
    if (!rst_n || !pwr_up) begin
      spi_so      <= 1'b0;
      spi_so_oe_n <= 1'b1;
      osr_q       <= 8'h00;
      obit_q      <= 3'h0;
      rd_adr_q    <= '0;
    end else if (spi_cs_n || st_q != sewg_pkg::st_read) begin
      spi_so_oe_n <= 1'b1;
      obit_q      <= 3'h0;
      if (byte_done && st_q == sewg_pkg::st_addr) begin
        rd_adr_q <= {adr_q[ADDR_W-9:0], byte_in};
      end
    end else if (sck_fall) begin
      spi_so_oe_n <= 1'b0;
      obit_q      <= obit_q + 3'h1;
      if (obit_q == 3'h0) begin
        // Status read repeats the live status byte
        if (op_q == sewg_pkg::OP_STATUS_READ_CMD) begin
          spi_so <= status[7];
          osr_q  <= {status[6:0], 1'b0};
        end else begin
          spi_so   <= mem[rd_adr_q][7];
          osr_q    <= {mem[rd_adr_q][6:0], 1'b0};
          rd_adr_q <= rd_adr_q + ADDR_W'(1);
        end
      end else begin
        spi_so <= osr_q[7];
        osr_q  <= {osr_q[6:0], 1'b0};
      end
    end
  end

  sewg_timer #(
    .CYCLES (WRITE_CYCLES)
  ) u_timer (
    .clock  (clock),
    .rst_n  (rst_n),
    .pwr_ok (pwr_up),
    .wc     (wc.tmr)
  );
endmodule : sewg_guard

// ===== verilog/sewg_pad.sv
// No logic: the guard's pins are plain ports, no pad cells are modelled

// ===== verilog/sewg_pkg.sv
// Constants, opcodes, status layout and state types of the write-state guard
// Function
// - Supply detector moves between reset and standby
// - Power-up leaves write latch clear, in standby
// - Instructions accepted only after chip select falls
// - Completed writes clear the write latch
// - Internal write starts only on exact release
// - Array access ignored during internal write
// - Unknown opcode ignored, output stays released
// - Only status read honoured during write
// - Busy bit high while internal write runs
// - Write-latch-clear command clears the latch
package sewg_pkg;
  // Instruction opcodes
  localparam logic [7:0] OP_WRSR                  = 8'h01;
  localparam logic [7:0] OP_WRITE                 = 8'h02;
  localparam logic [7:0] OP_READ                  = 8'h03;
  localparam logic [7:0] OP_WRITE_LATCH_CLEAR_CMD = 8'h04;
  localparam logic [7:0] OP_STATUS_READ_CMD       = 8'h05;
  localparam logic [7:0] OP_WRITE_LATCH_SET_CMD   = 8'h06;
  // Status register bit positions
  localparam int STAT_BUSY  = 0;
  localparam int STAT_LATCH = 1;
  localparam int STAT_BP0   = 2;
  localparam int STAT_BP1   = 3;
  localparam int STAT_WPEN  = 7;
  // Reset values
  localparam logic [7:0] STATUS_RST = 8'h00;
  // Self-timed write length and clock rate
  localparam int WRITE_TIME_NS = 5000;
  localparam int CLK_MHZ       = 200;
  localparam int WRITE_CYCLES  = (WRITE_TIME_NS * CLK_MHZ + 999) / 1000;
  // Array geometry
  localparam int ADDR_W    = 11;
  localparam int PAGE_BITS = 5;
  // Supply state
  typedef enum logic {pw_reset, pw_standby} sewg_pwr_type;
  // Selection state
  typedef enum logic [2:0] {
    st_idle, st_op, st_cmd, st_addr, st_wdata, st_wrsr, st_read, st_ignore
  } sewg_st_type;
endpackage : sewg_pkg

// ===== verilog/sewg_timer.sv
// Self-timed internal write cycle timer
`timescale 1ns/10ps
module sewg_timer #(
  parameter int CYCLES = sewg_pkg::WRITE_CYCLES  // Length of one write
) (
  input  wire logic clock,    // System clock
  input  wire logic rst_n,    // Synchronous reset, active low
  input  wire logic pwr_ok,   // Supply in standby range
  sewg_wc_if.tmr    wc        // Start, busy and done
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_q;   // Cycles elapsed
  logic          busy_q;  // Running flag
  logic          done_q;  // End pulse

  // Count a started write to its end; a brown-out aborts it
  always_ff @(posedge clock) begin
    if (!rst_n || !pwr_ok) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (busy_q) begin
        // Nothing from the bus can stop programming once begun
        if (cnt_q == LAST) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + CW'(1);
        end
      end else if (wc.start) begin
        busy_q <= 1'b1;
        cnt_q  <= '0;
      end
    end
  end

  assign wc.busy = busy_q;
  assign wc.done = done_q;
endmodule : sewg_timer

// ===== verilog/sewg_wc_if.sv
// Handshake between the command logic and the self-timed write timer
`timescale 1ns/10ps
interface sewg_wc_if;
  logic start;  // One-cycle start of an internal write
  logic busy;   // Internal write in progress
  logic done;   // One-cycle end of the internal write
  modport ctl (output start, input busy, input done);
  modport tmr (input start, output busy, output done);
endinterface : sewg_wc_if
